// file: simd_fp_pkg.sv
// Constants and types for the SIMD floating-point exception signalling block
package simd_fp_pkg;
    // ----------------------------------------
    // Sizes and register map
    // ----------------------------------------
    localparam int          LANES       = 4;
    localparam int          LANE_W      = 32;
    localparam logic [3:0]  CSR_OFF     = 4'h0;
    localparam logic [3:0]  FAULT_OFF   = 4'h4;
    localparam logic [3:0]  ENTRY_OFF   = 4'h8;
    // ----------------------------------------
    // Control/status field positions
    // ----------------------------------------
    localparam int          FLAG_LSB    = 0;
    localparam int          DAZ_BIT     = 6;
    localparam int          MASK_LSB    = 7;
    localparam int          FTZ_BIT     = 15;
    localparam int          CSR_W       = 16;
    localparam logic [15:0] CSR_RESET   = 16'h1f80;
    // ----------------------------------------
    // Fault entry
    // ----------------------------------------
    localparam logic [7:0]  FAULT_VEC   = 8'h13;
    localparam int          GATE_BIT    = 0;
    localparam int          IF_BIT      = 9;
    localparam logic        GATE_RESET  = 1'b1;
    localparam logic        IF_RESET    = 1'b1;
    localparam logic [31:0] QNAN_INDEF  = 32'hffc00000;

    typedef logic [LANES-1:0][LANE_W-1:0] lanes_t;

    typedef struct packed {
        logic             valid;
        logic             isPacked;
        logic             divide;
        logic [7:0]       tag;
        lanes_t           srcA;
        lanes_t           srcB;
        lanes_t           computed;
        logic [LANES-1:0][2:0] post;
    } op_t;

    typedef struct packed {
        logic             valid;
        logic [7:0]       tag;
        lanes_t           data;
    } wb_t;

    typedef struct packed {
        logic             valid;
        logic [7:0]       tag;
        logic [7:0]       vector;
        logic [5:0]       cause;
    } fault_t;
endpackage

// file: lane_classify.sv
// Operand checks of one lane, made before the arithmetic
module lane_classify (
    input  wire logic [31:0] a,
    input  wire logic [31:0] b,
    input  wire logic        divide,
    input  wire logic        daz,
    output logic      [2:0]  pre,
    output logic      [31:0] defaultValue
);
    logic nanA, nanB, snanA, snanB, infA, infB, zA, zB, denA, denB;
    logic invalid, divZero, denormal;

    always_comb begin
        nanA  = (a[30:23] == 8'hff) && (a[22:0] != 23'h0);
        nanB  = (b[30:23] == 8'hff) && (b[22:0] != 23'h0);
        snanA = nanA && !a[22];
        snanB = nanB && !b[22];
        infA  = (a[30:23] == 8'hff) && (a[22:0] == 23'h0);
        infB  = (b[30:23] == 8'hff) && (b[22:0] == 23'h0);
        denA  = (a[30:23] == 8'h00) && (a[22:0] != 23'h0);
        denB  = (b[30:23] == 8'h00) && (b[22:0] != 23'h0);
        // Denormals read as zero only when that mode is on
        zA    = (a[30:0] == 31'h0) || (denA && daz);
        zB    = (b[30:0] == 31'h0) || (denB && daz);
        invalid = snanA || snanB
                || (divide && ((zA && zB) || (infA && infB)))
                || (!divide && infA && infB && (a[31] != b[31]));
        divZero  = divide && zB && !zA && !nanA && !infA;
        denormal = (denA || denB) && !daz;
        pre = {divZero, denormal, invalid};
        if (snanA) begin
            defaultValue = a | 32'h00400000;
        end else if (snanB) begin
            defaultValue = b | 32'h00400000;
        end else if (invalid) begin
            defaultValue = simd_fp_pkg::QNAN_INDEF;
        end else begin
            defaultValue = {a[31] ^ b[31], 8'hff, 23'h0};
        end
    end
endmodule // lane_classify

// file: lane_resolve.sv
// Masking and result choice of one lane
module lane_resolve (
    input  wire logic [2:0]  pre,
    input  wire logic [2:0]  post,
    input  wire logic [5:0]  masks,
    input  wire logic        ftz,
    input  wire logic [31:0] computed,
    input  wire logic [31:0] defaultValue,
    output logic      [5:0]  flags,
    output logic      [31:0] result
);
    logic preStop;

    always_comb begin
        // Invalid or divide-by-zero means no arithmetic, so no late conditions
        preStop = pre[0] || pre[2] || |(pre & ~masks[2:0]);
        flags   = {preStop ? 3'h0 : post, pre};
        if (pre[0] || pre[2]) begin
            result = defaultValue;
        end else if (ftz && post[1] && masks[4]) begin
            result = {computed[31], 31'h0};
        end else begin
            result = computed;
        end
    end
endmodule // lane_resolve

// file: simd_fp_exception.sv
// SIMD floating-point exception signalling unit with its control registers
module simd_fp_exception (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [3:0]          regAddr,
    input  wire logic [31:0]         regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [31:0]         regRdata,
    input  wire simd_fp_pkg::op_t    opIn,
    output simd_fp_pkg::wb_t         wbOut,
    output simd_fp_pkg::fault_t      faultOut,
    output logic                     intEnable
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0]          csr;
        logic                 gateIsInt;
        logic                 ifl;
        logic [5:0]           lastCause;
        logic [15:0]          faultCount;
        logic [31:0]          rdata;
        simd_fp_pkg::wb_t     wb;
        simd_fp_pkg::fault_t  fault;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // ----------------------------------------
    // Per-lane checks
    // ----------------------------------------
    logic [simd_fp_pkg::LANES-1:0][2:0]  lanePre;
    logic [simd_fp_pkg::LANES-1:0][5:0]  laneFlags;
    simd_fp_pkg::lanes_t                 laneDefault;
    simd_fp_pkg::lanes_t                 laneResult;
    logic [simd_fp_pkg::LANES-1:0]       laneOn;
    logic [5:0]                          masks;
    logic                                daz;
    logic                                ftz;

    assign masks = st_reg.csr[simd_fp_pkg::MASK_LSB +: 6];
    assign daz   = st_reg.csr[simd_fp_pkg::DAZ_BIT];
    assign ftz   = st_reg.csr[simd_fp_pkg::FTZ_BIT];

    genvar g;
    generate
        for (g = 0; g < simd_fp_pkg::LANES; g++) begin : gLane
            // Scalar work uses lane 0 only; upper lanes pass through
            assign laneOn[g] = (g == 0) || opIn.isPacked;

            lane_classify uClassify (
                .a            (opIn.srcA[g]),
                .b            (opIn.srcB[g]),
                .divide       (opIn.divide),
                .daz          (daz),
                .pre          (lanePre[g]),
                .defaultValue (laneDefault[g])
            );

            lane_resolve uResolve (
                .pre          (lanePre[g]),
                .post         (opIn.post[g]),
                .masks        (masks),
                .ftz          (ftz),
                .computed     (opIn.computed[g]),
                .defaultValue (laneDefault[g]),
                .flags        (laneFlags[g]),
                .result       (laneResult[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Lane merge
    // ----------------------------------------
    logic [5:0]          raised;
    logic [5:0]          unmasked;
    logic                faultNow;
    simd_fp_pkg::lanes_t wbData;

    always_comb begin
        raised = 6'h0;
        wbData = opIn.srcA;
        for (int i = 0; i < simd_fp_pkg::LANES; i++) begin
            if (laneOn[i]) begin
                raised    = raised | laneFlags[i];
                wbData[i] = laneResult[i];
            end
        end
        // Only this instruction's conditions count, never the stored flags
        unmasked = raised & ~masks;
        faultNow = opIn.valid && (unmasked != 6'h0);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next             = st_reg;
        st_next.rdata       = 32'h0;
        st_next.wb.valid    = 1'b0;
        st_next.fault.valid = 1'b0;

        if (regWr) begin
            case (regAddr)
                simd_fp_pkg::CSR_OFF: begin
                    st_next.csr = regWdata[simd_fp_pkg::CSR_W-1:0];
                end
                simd_fp_pkg::ENTRY_OFF: begin
                    st_next.gateIsInt = regWdata[simd_fp_pkg::GATE_BIT];
                    st_next.ifl       = regWdata[simd_fp_pkg::IF_BIT];
                end
                default: begin
                end
            endcase
        end

        // New operation accepted every cycle, no waiting on others
        if (opIn.valid) begin
            if (faultNow) begin
                // Report against this very instruction, in the next cycle
                st_next.fault.valid  = 1'b1;
                st_next.fault.tag    = opIn.tag;
                st_next.fault.vector = simd_fp_pkg::FAULT_VEC;
                st_next.fault.cause  = raised;
                st_next.lastCause    = raised;
                st_next.faultCount   = st_reg.faultCount + 16'h1;
                if (st_reg.gateIsInt) begin
                    st_next.ifl = 1'b0;
                end
                // No write-back and no flag update: restartable
            end else begin
                st_next.wb.valid = 1'b1;
                st_next.wb.tag   = opIn.tag;
                st_next.wb.data  = wbData;
                // Hardware set wins over a same-cycle software clear
                st_next.csr[simd_fp_pkg::FLAG_LSB +: 6] =
                    st_next.csr[simd_fp_pkg::FLAG_LSB +: 6] | raised;
            end
        end

        if (regRd) begin
            case (regAddr)
                simd_fp_pkg::CSR_OFF: begin
                    st_next.rdata = {16'h0, st_reg.csr};
                end
                simd_fp_pkg::FAULT_OFF: begin
                    st_next.rdata = {st_reg.faultCount,
                                     simd_fp_pkg::FAULT_VEC,
                                     2'h0, st_reg.lastCause};
                end
                simd_fp_pkg::ENTRY_OFF: begin
                    st_next.rdata = 32'h0;
                    st_next.rdata[simd_fp_pkg::GATE_BIT] = st_reg.gateIsInt;
                    st_next.rdata[simd_fp_pkg::IF_BIT]   = st_reg.ifl;
                end
                default: begin
                    st_next.rdata = 32'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg            <= '0;
            st_reg.csr        <= simd_fp_pkg::CSR_RESET;
            st_reg.gateIsInt  <= simd_fp_pkg::GATE_RESET;
            st_reg.ifl        <= simd_fp_pkg::IF_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdata  = st_reg.rdata;
    assign wbOut     = st_reg.wb;
    assign faultOut  = st_reg.fault;
    assign intEnable = st_reg.ifl;
endmodule // simd_fp_exception

// file: fault_dispatch_model.sv
// Exception dispatch model: counts handler entries taken on the fault port
module fault_dispatch_model (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire simd_fp_pkg::fault_t faultOut,
    output logic [15:0]              entries
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only the vector 19 entry of the descriptor table is populated
    always_ff @(posedge clock) begin
        if (rst) begin
            entries <= 16'h0000;
        end else if (faultOut.valid && faultOut.vector == 8'h13) begin
            entries <= entries + 16'h0001;
        end
    end
endmodule // fault_dispatch_model

// file: simd_fp_exception_asserts.sv
// Port checks for the SIMD floating-point exception unit
module simd_fp_exception_asserts (
    input wire logic                clock,
    input wire logic                rst,
    input wire logic [3:0]          regAddr,
    input wire logic [31:0]         regWdata,
    input wire logic                regWr,
    input wire logic                regRd,
    input wire logic [31:0]         regRdata,
    input wire simd_fp_pkg::op_t    opIn,
    input wire simd_fp_pkg::wb_t    wbOut,
    input wire simd_fp_pkg::fault_t faultOut,
    input wire logic                intEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_oneAnswer; opIn.valid |=> wbOut.valid != faultOut.valid; endproperty
    a_oneAnswer: assert property (p_oneAnswer) else $error("op answer missing");
    property p_noStray; !opIn.valid |=> !wbOut.valid && !faultOut.valid; endproperty
    a_noStray: assert property (p_noStray) else $error("answer without op");
    property p_vector;
        faultOut.valid |-> faultOut.vector == 8'h13 && faultOut.cause != 6'h00;
    endproperty
    a_vector: assert property (p_vector) else $error("bad fault vector");
    property p_faultTag; faultOut.valid |-> faultOut.tag == $past(opIn.tag); endproperty
    a_faultTag: assert property (p_faultTag) else $error("fault tag wrong");
    property p_wbTag; wbOut.valid |-> wbOut.tag == $past(opIn.tag); endproperty
    a_wbTag: assert property (p_wbTag) else $error("write-back tag wrong");
    property p_quiet;
        wbOut.valid && !$past(regWr) |-> intEnable == $past(intEnable);
    endproperty
    a_quiet: assert property (p_quiet) else $error("masked op touched flags");
    property p_ifFall; $fell(intEnable) |-> faultOut.valid || $past(regWr); endproperty
    a_ifFall: assert property (p_ifFall) else $error("enable fell alone");
    property p_scalar;
        wbOut.valid && !$past(opIn.isPacked) |-> wbOut.data[3:1] == $past(opIn.srcA[3:1]);
    endproperty
    a_scalar: assert property (p_scalar) else $error("scalar upper lanes");
endmodule // simd_fp_exception_asserts

bind simd_fp_exception simd_fp_exception_asserts u_chk (.clock(clock), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .opIn(opIn), .wbOut(wbOut), .faultOut(faultOut),
    .intEnable(intEnable));

// file: simd_fp_exception_tb.sv
// Register and operation tests of the SIMD floating-point exception unit
module simd_fp_exception_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clock = 1'b0;
    logic                rst = 1'b1;
    logic [3:0]          regAddr = 4'h0;
    logic [31:0]         regWdata = 32'h0;
    logic                regWr = 1'b0;
    logic                regRd = 1'b0;
    logic [31:0]         regRdata;
    simd_fp_pkg::op_t    opIn = '0;
    simd_fp_pkg::wb_t    wbOut;
    simd_fp_pkg::fault_t faultOut;
    logic                intEnable;
    logic [15:0]         entries;
    int                  n_errors = 0;
    int                  compares = 0;
    int                  cycles = 0;

    always #5 clock = ~clock;
    simd_fp_exception DUT (.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .opIn(opIn), .wbOut(wbOut),
        .faultOut(faultOut), .intEnable(intEnable));
    fault_dispatch_model partner (.clock(clock), .rst(rst), .faultOut(faultOut),
        .entries(entries));

    task automatic end_of_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, well above the fewer than a hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdReg(input logic [3:0] a, input logic [31:0] exp, input string name);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 chk(name, exp, regRdata);
    endtask
    function automatic simd_fp_pkg::op_t mkOp(input logic pk, input logic dv,
                      input logic [7:0] t,
                      input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                      input logic [11:0] post);
        simd_fp_pkg::op_t v;
        v.valid = 1'b1;
        v.isPacked = pk;
        v.divide = dv;
        v.tag = t;
        v.srcA = {4{a}};
        v.srcB = {4{b}};
        v.computed = {4{c}};
        v.post = post;
        return v;
    endfunction
    task automatic op(input logic pk, input logic dv, input logic [7:0] t,
                      input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                      input logic [11:0] post);
        @(posedge clock);
        opIn <= mkOp(pk, dv, t, a, b, c, post);
        @(posedge clock);
        opIn.valid <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rdReg(4'h0, 32'h1f80, "csrReset");
        rdReg(4'h8, 32'h0201, "entryReset");
        rdReg(4'hc, 32'h0, "unmapped");
        // Masked divide by zero gives signed infinity and a sticky flag
        op(1'b0, 1'b1, 8'h01, 32'h3f800000, 32'h0, 32'h0, 12'h000);
        chk("wbValid", 32'h1, wbOut.valid);
        chk("faultQuiet", 32'h0, faultOut.valid);
        chk("infResult", 32'h7f800000, wbOut.data[0]);
        rdReg(4'h0, 32'h1f84, "zFlag");
        // Packed: overflow on lane 1, inexact on lane 3
        wr(4'h0, 32'h1f80);
        op(1'b1, 1'b0, 8'h02, 32'h3f800000, 32'h3f800000, 32'h40000000, 12'h808);
        chk("packedWb", 32'h1, wbOut.valid);
        chk("lane0", 32'h40000000, wbOut.data[0]);
        rdReg(4'h0, 32'h1fa8, "orFlags");
        // Old flag left set while unmasked must stay silent
        wr(4'h0, 32'h1d84);
        op(1'b0, 1'b0, 8'h03, 32'h3f800000, 32'h3f800000, 32'h40000000, 12'h000);
        chk("staleFlag", 32'h0, faultOut.valid);
        chk("staleWb", 32'h1, wbOut.valid);
        op(1'b0, 1'b1, 8'h04, 32'h3f800000, 32'h0, 32'h0, 12'h000);
        chk("zFault", 32'h1, faultOut.valid);
        chk("vector", 32'h13, faultOut.vector);
        chk("faultTag", 32'h04, faultOut.tag);
        chk("cause", 32'h04, faultOut.cause);
        chk("noWb", 32'h0, wbOut.valid);
        chk("ifCleared", 32'h0, intEnable);
        rdReg(4'h0, 32'h1d84, "flagsKept");
        rdReg(4'h4, 32'h00011304, "faultInfo");
        wr(4'h4, 32'hffffffff);
        rdReg(4'h4, 32'h00011304, "infoReadOnly");
        wr(4'h8, 32'h0201);
        rdReg(4'h8, 32'h0201, "entryRestore");
        chk("ifBack", 32'h1, intEnable);
        // Unmasked overflow: fault, no rounded result
        wr(4'h0, 32'h1b80);
        op(1'b0, 1'b0, 8'h05, 32'h7f000000, 32'h7f000000, 32'h7f800000, 12'h001);
        chk("oFault", 32'h1, faultOut.valid);
        chk("oNoWb", 32'h0, wbOut.valid);
        chk("oCause", 32'h08, faultOut.cause);
        rdReg(4'h4, 32'h00021308, "infoCount");
        chk("entries", 32'h2, entries);
        // Masked invalid: default NaN, late conditions dropped, upper lanes kept
        wr(4'h0, 32'h1f80);
        op(1'b0, 1'b0, 8'h08, 32'h7f800000, 32'hff800000, 32'h0, 12'h004);
        chk("invDefault", 32'hffc00000, wbOut.data[0]);
        chk("upperLane", 32'h7f800000, wbOut.data[1]);
        rdReg(4'h0, 32'h1f81, "invFlag");
        // Denormal operand flagged only while denormals-are-zero is off
        wr(4'h0, 32'h1f80);
        op(1'b0, 1'b0, 8'h09, 32'h00000001, 32'h3f800000, 32'h3f800000, 12'h000);
        chk("denResult", 32'h3f800000, wbOut.data[0]);
        rdReg(4'h0, 32'h1f82, "dFlag");
        wr(4'h0, 32'h1fc0);
        op(1'b0, 1'b0, 8'h0a, 32'h00000001, 32'h3f800000, 32'h3f800000, 12'h000);
        rdReg(4'h0, 32'h1fc0, "dazNoFlag");
        // Flush-to-zero with masked underflow gives a signed zero
        wr(4'h0, 32'h9f80);
        op(1'b0, 1'b0, 8'h0b, 32'h3f800000, 32'h3f800000, 32'h80000001, 12'h002);
        chk("ftzZero", 32'h80000000, wbOut.data[0]);
        rdReg(4'h0, 32'h9f90, "uFlag");
        // Back-to-back operations, the second one faulting
        wr(4'h0, 32'h1d80);
        @(posedge clock);
        opIn <= mkOp(1'b0, 1'b0, 8'h0c, 32'h3f800000, 32'h3f800000, 32'h40000000, 12'h000);
        @(posedge clock);
        opIn <= mkOp(1'b0, 1'b1, 8'h0d, 32'h3f800000, 32'h0, 32'h0, 12'h000);
        #1 chk("b2bWb", 32'h10c, {wbOut.valid, wbOut.tag});
        @(posedge clock);
        opIn.valid <= 1'b0;
        #1 chk("b2bFault", 32'h10d, {faultOut.valid, faultOut.tag});
        rdReg(4'h4, 32'h00031304, "info3");
        chk("entries3", 32'h3, entries);
        @(posedge clock);
        #1 chk("rdataDrop", 32'h0, regRdata);
        end_of_test();
    end
endmodule // simd_fp_exception_tb
